// ==== hdl/bms_params.svh ====
// Constants for the battery measurement sequencer: channel map, slot counts,
// timing figures and converter gains. Assumes a 250 MHz system clock.
`ifndef BMS_PARAMS_SVH
`define BMS_PARAMS_SVH

`define BMS_NUM_CELLS 16
`define BMS_NUM_AUX 9
`define BMS_NUM_CH 32
`define BMS_BASE_SLOTS 5'h12
`define BMS_MAX_AUX_SLOTS 2'h3
`define BMS_ROT_LAST 2'h2
`define BMS_SLOT_STACK 5'h10
`define BMS_SLOT_TEMP 5'h11
`define BMS_CH_STACK 5'h10
`define BMS_CH_TEMP 5'h13
`define BMS_CH_AUX0 5'h16
`define BMS_CLK_NS 4
`define BMS_SLOT_NS 3000000
`define BMS_SLOT_FAST_NS 1500000
`define BMS_CC1_NS 250000000
`define BMS_SEC_NS 1000000000
`define BMS_SLOT_CYC (`BMS_SLOT_NS / `BMS_CLK_NS)
`define BMS_SLOT_FAST_CYC (`BMS_SLOT_FAST_NS / `BMS_CLK_NS)
`define BMS_CC1_CYC (`BMS_CC1_NS / `BMS_CLK_NS)
`define BMS_SEC_CYC (`BMS_SEC_NS / `BMS_CLK_NS)
`define BMS_CELL_GAIN 16'h2f58
`define BMS_AUX_GAIN 16'h0fc8
`define BMS_FS_CODE 24'h7fffff
`define BMS_FAST_MASK 24'hfffff0
`define BMS_CHARGE_SHIFT 30

`endif

// ==== hdl/bms_pkg.sv ====
// Types shared by the battery measurement sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package bms_pkg;
    typedef enum logic [1:0] {
        BMS_OFF  = 2'h0,
        BMS_CONV = 2'h1,
        BMS_HOLD = 2'h3,
        BMS_IDLE = 2'h2
    } bms_state_t;
endpackage

// ==== hdl/bms_meas_seq.sv ====
// Battery measurement sequencer: slot loop for the muxed voltage converter,
// result store, current filters and charge integration.
// Converter and current decimator run on clk_sys; their signals are not
// synchronised. Gain and offset correction beyond the nominal gain is absent.
`include "bms_params.svh"

module bms_meas_seq #(
    parameter int unsigned SLOT_CYC = `BMS_SLOT_CYC,
    parameter int unsigned SLOT_FAST_CYC = `BMS_SLOT_FAST_CYC,
    parameter int unsigned CC1_CYC = `BMS_CC1_CYC,
    parameter int unsigned SEC_CYC = `BMS_SEC_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic run_en,
    input wire logic fast_slot,
    input wire logic [7:0] idle_slots,
    input wire logic [15:0] cell_used,
    input wire logic [8:0] aux_en,
    input wire logic [7:0] avg_count,
    input wire logic host_reset_cmd,
    input wire logic [15:0] suv_threshold_mv,
    input wire logic [7:0] suv_delay_s,
    output logic adc_start_q,
    output logic [4:0] adc_chan_q,
    output logic adc_bandgap_q,
    input wire logic adc_done,
    input wire logic [23:0] adc_data,
    input wire logic adc_ovr,
    input wire logic cc_valid,
    input wire logic [23:0] cc_data,
    input wire logic [4:0] rd_sel,
    output logic [15:0] rd_mv_q,
    output logic [31:0] rd_raw_q,
    output logic [15:0] rd_cur_q,
    output logic [15:0] slow_cur_q,
    output logic slow_valid_q,
    output logic [15:0] fast_cur_q,
    output logic [31:0] fast_raw_q,
    output logic [31:0] avg_cur_q,
    output logic [63:0] charge_q,
    output logic [31:0] charge_time_q,
    output logic [31:0] ts1_raw_q,
    output logic [15:0] cell_prot_en_q,
    output logic suv_alert_q,
    output logic suv_fault_q,
    output logic [4:0] loop_len_q,
    output logic loop_done_q
);
    function automatic logic [4:0] loop_len(input logic [8:0] en);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < `BMS_NUM_AUX; i++) begin
            n = n + {3'h0, en[i]};
        end
        if (n > {2'h0, `BMS_MAX_AUX_SLOTS}) begin
            n = {2'h0, `BMS_MAX_AUX_SLOTS};
        end
        return `BMS_BASE_SLOTS + {1'h0, n};
    endfunction
    // Next enabled auxiliary pin at or after ptr, wrapping round.
    function automatic logic [3:0] next_aux(input logic [8:0] en,
                                            input logic [3:0] ptr);
        logic [3:0] pick, k;
        logic found;
        pick = 4'h0;
        found = 1'b0;
        for (int i = 0; i < `BMS_NUM_AUX; i++) begin
            k = 4'((int'(ptr) + i) % `BMS_NUM_AUX);
            if (!found && en[k]) begin
                pick = k;
                found = 1'b1;
            end
        end
        return pick;
    endfunction
    function automatic logic [15:0] to_mv(input logic [23:0] code,
                                          input logic [15:0] gain);
        logic signed [31:0] p;
        p = $signed(code[23:8]) * $signed({1'b0, gain});
        return p[31:16];
    endfunction
    bms_pkg::bms_state_t state_q;
    logic [4:0] slot_q;
    logic [7:0] idle_q, avg_n_q, div_den_q, suv_sec_q;
    logic [1:0] rot_q;
    logic [3:0] aux_ptr_q;
    logic [31:0] slot_cnt_q, fast_cnt_q, cc1_cnt_q, sec_cnt_q;
    logic [15:0] mv_mem [`BMS_NUM_CH];
    logic [31:0] raw_mem [`BMS_NUM_CH];
    logic [15:0] cur_mem [`BMS_NUM_CELLS];
    logic [23:0] cc_last_q;
    logic [31:0] avg_sum_q, div_q;
    logic [8:0] div_rem_q;
    logic [5:0] div_step_q;
    logic div_neg_q;

    logic slot_end, fast_tick, sec_tick;
    logic [31:0] slot_len, avg_total;
    logic [4:0] meas_ch;
    logic [3:0] aux_pick;
    logic [23:0] code, fast_next;
    logic [15:0] mv_now;
    assign slot_len = fast_slot ? SLOT_FAST_CYC : SLOT_CYC;
    assign slot_end = (slot_cnt_q == 32'h0);
    assign fast_tick = (fast_cnt_q == 32'h0);
    assign sec_tick = (sec_cnt_q == 32'h0);
    assign aux_pick = next_aux(aux_en, aux_ptr_q);
    assign code = adc_ovr ? `BMS_FS_CODE : adc_data;
    assign mv_now = to_mv(code, (adc_chan_q >= `BMS_CH_AUX0) ?
                          `BMS_AUX_GAIN : `BMS_CELL_GAIN);
    assign fast_next = fast_slot ? (cc_last_q & `BMS_FAST_MASK)
                                 : cc_last_q;
    // Running sum including the sample of this tick; its sign drives the
    // magnitude divide so negative currents round toward zero.
    assign avg_total = avg_sum_q + {{8{fast_next[23]}}, fast_next};
    // Channel for the slot that begins next, from the loop position.
    always_comb begin
        if (slot_q < `BMS_SLOT_STACK) begin
            meas_ch = slot_q;
        end else if (slot_q == `BMS_SLOT_STACK) begin
            meas_ch = `BMS_CH_STACK + {3'h0, rot_q};
        end else if (slot_q == `BMS_SLOT_TEMP) begin
            meas_ch = `BMS_CH_TEMP + {3'h0, rot_q};
        end else begin
            meas_ch = `BMS_CH_AUX0 + {1'h0, aux_pick};
        end
    end

    // Slot sequencer. A loop is the measurement slots, then idle slots.
    always_ff @(posedge clk_sys) begin
        adc_start_q <= 1'b0;
        loop_done_q <= 1'b0;
        if (!rst_n || !run_en) begin
            state_q <= bms_pkg::BMS_OFF;
            slot_q <= 5'h0;
            idle_q <= 8'h0;
            rot_q <= 2'h0;
            aux_ptr_q <= 4'h0;
            slot_cnt_q <= 32'h0;
            adc_chan_q <= 5'h0;
            adc_bandgap_q <= 1'b0;
            loop_len_q <= rst_n ? loop_len(aux_en) : `BMS_BASE_SLOTS;
        end else begin
            slot_cnt_q <= slot_end ? 32'h0 : slot_cnt_q - 32'h1;
            if (state_q == bms_pkg::BMS_CONV && adc_done) begin
                state_q <= bms_pkg::BMS_HOLD;
            end
            if (state_q == bms_pkg::BMS_OFF || slot_end) begin
                slot_cnt_q <= slot_len - 32'h1;
                if (slot_q < loop_len_q) begin
                    state_q <= bms_pkg::BMS_CONV;
                    adc_start_q <= 1'b1;
                    adc_chan_q <= meas_ch;
                    adc_bandgap_q <= (meas_ch >= `BMS_CH_AUX0);
                    if (slot_q >= `BMS_BASE_SLOTS) begin
                        aux_ptr_q <= (aux_pick == 4'h8) ? 4'h0
                                                        : aux_pick + 4'h1;
                    end
                    slot_q <= slot_q + 5'h1;
                end else if (idle_q < idle_slots) begin
                    state_q <= bms_pkg::BMS_IDLE;
                    idle_q <= idle_q + 8'h1;
                end else begin
                    // New loop: restart at the first cell.
                    state_q <= bms_pkg::BMS_CONV;
                    adc_start_q <= 1'b1;
                    adc_chan_q <= 5'h0;
                    adc_bandgap_q <= 1'b0;
                    slot_q <= 5'h1;
                    idle_q <= 8'h0;
                    loop_done_q <= 1'b1;
                    loop_len_q <= loop_len(aux_en);
                    rot_q <= (rot_q == `BMS_ROT_LAST) ? 2'h0
                                                      : rot_q + 2'h1;
                end
            end
        end
    end

    // Result store. Every channel keeps both formats.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int i = 0; i < `BMS_NUM_CH; i++) begin
                mv_mem[i] <= 16'h0;
                raw_mem[i] <= 32'h0;
            end
            for (int i = 0; i < `BMS_NUM_CELLS; i++) begin
                cur_mem[i] <= 16'h0;
            end
            ts1_raw_q <= 32'h0;
        end else if (state_q == bms_pkg::BMS_CONV && adc_done) begin
            mv_mem[adc_chan_q] <= mv_now;
            raw_mem[adc_chan_q] <= {{8{code[23]}}, code};
            if (adc_chan_q < `BMS_CH_STACK) begin
                cur_mem[adc_chan_q[3:0]] <= fast_cur_q;
            end
            if (adc_chan_q == `BMS_CH_AUX0) begin
                ts1_raw_q <= {{8{code[23]}}, code};
            end
        end
    end

    // Registered readout; cell entries return voltage and current together.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_mv_q <= 16'h0;
            rd_raw_q <= 32'h0;
            rd_cur_q <= 16'h0;
            cell_prot_en_q <= 16'h0;
        end else begin
            rd_mv_q <= mv_mem[rd_sel];
            rd_raw_q <= raw_mem[rd_sel];
            rd_cur_q <= (rd_sel < `BMS_CH_STACK) ? cur_mem[rd_sel[3:0]]
                                                  : 16'h0;
            cell_prot_en_q <= cell_used;
        end
    end

    // Low first-cell reading raises the alert; escalation counts suv_delay_s second ticks
    // while it is held, so with a delay of 1 a lone bad sample held for one loop can.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            suv_alert_q <= 1'b0;
            suv_fault_q <= 1'b0;
            suv_sec_q <= 8'h0;
        end else begin
            if (state_q == bms_pkg::BMS_CONV && adc_done &&
                adc_chan_q == 5'h0) begin
                suv_alert_q <= $signed(mv_now) <
                               $signed(suv_threshold_mv);
            end
            if (!suv_alert_q) begin
                suv_sec_q <= 8'h0;
            end else if (sec_tick && suv_sec_q != 8'hff) begin
                suv_sec_q <= suv_sec_q + 8'h1;
            end
            if (suv_alert_q && suv_sec_q >= suv_delay_s &&
                suv_delay_s != 8'h0) begin
                suv_fault_q <= 1'b1;
            end
        end
    end

    // Fast filter: one result per slot period from the latest sample.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cc_last_q <= 24'h0;
            fast_cnt_q <= 32'h0;
            fast_cur_q <= 16'h0;
            fast_raw_q <= 32'h0;
        end else begin
            cc_last_q <= cc_valid ? cc_data : cc_last_q;
            fast_cnt_q <= fast_tick ? slot_len - 32'h1
                                    : fast_cnt_q - 32'h1;
            if (fast_tick) begin
                fast_cur_q <= fast_next[23:8];
                fast_raw_q <= {{8{fast_next[23]}}, fast_next};
            end
        end
    end

    // Slow filter and charge integration. Each slow result adds a quarter
    // second of current, i.e. the sample shifted into 32.32 fixed point.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cc1_cnt_q <= CC1_CYC - 32'h1;
            sec_cnt_q <= SEC_CYC - 32'h1;
            slow_cur_q <= 16'h0;
            slow_valid_q <= 1'b0;
            charge_q <= 64'h0;
            charge_time_q <= 32'h0;
        end else begin
            slow_valid_q <= 1'b0;
            cc1_cnt_q <= (cc1_cnt_q == 32'h0) ? CC1_CYC - 32'h1
                                              : cc1_cnt_q - 32'h1;
            sec_cnt_q <= sec_tick ? SEC_CYC - 32'h1 : sec_cnt_q - 32'h1;
            if (cc1_cnt_q == 32'h0) begin
                slow_cur_q <= fast_raw_q[23:8];
                slow_valid_q <= 1'b1;
                charge_q <= charge_q + ({{48{fast_raw_q[23]}},
                            fast_raw_q[23:8]} << `BMS_CHARGE_SHIFT);
            end
            charge_time_q <= charge_time_q + {31'h0, sec_tick};
            if (host_reset_cmd) begin
                charge_q <= 64'h0;
                charge_time_q <= 32'h0;
            end
        end
    end

    // Averaged result: sum avg_count fast samples, then a serial divide.
    // The divide takes 33 cycles, far below one slot, so it never overlaps.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            avg_sum_q <= 32'h0;
            avg_n_q <= 8'h0;
            div_q <= 32'h0;
            div_rem_q <= 9'h0;
            div_den_q <= 8'h1;
            div_step_q <= 6'h0;
            div_neg_q <= 1'b0;
            avg_cur_q <= 32'h0;
        end else begin
            if (fast_tick && avg_count != 8'h0) begin
                if (avg_n_q + 8'h1 >= avg_count) begin
                    div_neg_q <= avg_total[31];
                    div_q <= (avg_total ^ {32{avg_total[31]}})
                             + {31'h0, avg_total[31]};
                    div_den_q <= avg_count;
                    div_rem_q <= 9'h0;
                    div_step_q <= 6'h20;
                    avg_sum_q <= 32'h0;
                    avg_n_q <= 8'h0;
                end else begin
                    avg_sum_q <= avg_total;
                    avg_n_q <= avg_n_q + 8'h1;
                end
            end
            if (div_step_q != 6'h0) begin
                if ({div_rem_q[7:0], div_q[31]} >= {1'b0, div_den_q}) begin
                    div_rem_q <= {div_rem_q[7:0], div_q[31]}
                                 - {1'b0, div_den_q};
                    div_q <= {div_q[30:0], 1'b1};
                end else begin
                    div_rem_q <= {div_rem_q[7:0], div_q[31]};
                    div_q <= {div_q[30:0], 1'b0};
                end
                div_step_q <= div_step_q - 6'h1;
            end else if (div_den_q != 8'h0) begin
                avg_cur_q <= div_neg_q ? 32'h0 - div_q : div_q;
                div_den_q <= 8'h0;
            end
        end
    end

endmodule

// ==== dv/bms_meas_seq_sva.sv ====
// Port-level checker for the measurement sequencer.
// Assumes one clock domain with a synchronous active-low reset.
module bms_meas_seq_sva #(
    parameter int unsigned SLOT_CYC = 40,
    parameter int unsigned SLOT_FAST_CYC = 20,
    parameter int unsigned CC1_CYC = 800,
    parameter int unsigned SEC_CYC = 1600
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic run_en,
    input wire logic [15:0] cell_used,
    input wire logic host_reset_cmd,
    input wire logic adc_start_q,
    input wire logic [4:0] adc_chan_q,
    input wire logic adc_bandgap_q,
    input wire logic [4:0] rd_sel,
    input wire logic [31:0] rd_raw_q,
    input wire logic [15:0] rd_cur_q,
    input wire logic [15:0] fast_cur_q,
    input wire logic [31:0] fast_raw_q,
    input wire logic [63:0] charge_q,
    input wire logic [31:0] charge_time_q,
    input wire logic [15:0] cell_prot_en_q
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // Stopping the loop may restart a slot early, so a stop aborts this.
    property p_start_pulse;
        disable iff (!rst_n || !run_en)
        adc_start_q |=> !adc_start_q [*8];
    endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("conversion start not a lone pulse");
    property p_bandgap;
        adc_start_q |-> adc_bandgap_q == (adc_chan_q >= 5'h16);
    endproperty
    a_bandgap: assert property (p_bandgap)
        else $error("reference choice wrong for channel");
    property p_chan_range;
        adc_start_q |-> adc_chan_q <= 5'h1e;
    endproperty
    a_chan_range: assert property (p_chan_range)
        else $error("conversion on unknown channel");
    property p_prot_en;
        $past(rst_n) |-> cell_prot_en_q == $past(cell_used);
    endproperty
    a_prot_en: assert property (p_prot_en)
        else $error("protection enables do not follow cell map");
    property p_host_clr;
        host_reset_cmd |=> charge_q == 64'h0 && charge_time_q == 32'h0;
    endproperty
    a_host_clr: assert property (p_host_clr)
        else $error("charge not cleared by host reset");
    property p_fast_sext;
        fast_raw_q[31:24] == {8{fast_raw_q[23]}} &&
            fast_cur_q == fast_raw_q[23:8];
    endproperty
    a_fast_sext: assert property (p_fast_sext)
        else $error("fast current formats disagree");
    property p_rd_sext;
        rd_raw_q[31:24] == {8{rd_raw_q[23]}};
    endproperty
    a_rd_sext: assert property (p_rd_sext)
        else $error("raw voltage word not sign extended");
    property p_cur_pair;
        rd_sel >= 5'h10 |=> rd_cur_q == 16'h0;
    endproperty
    a_cur_pair: assert property (p_cur_pair)
        else $error("paired current on a non-cell channel");
endmodule

bind bms_meas_seq bms_meas_seq_sva #(.SLOT_CYC(SLOT_CYC),
    .SLOT_FAST_CYC(SLOT_FAST_CYC), .CC1_CYC(CC1_CYC), .SEC_CYC(SEC_CYC))
    u_sva (.clk_sys, .rst_n, .run_en, .cell_used, .host_reset_cmd,
    .adc_start_q,
    .adc_chan_q, .adc_bandgap_q, .rd_sel, .rd_raw_q, .rd_cur_q, .fast_cur_q,
    .fast_raw_q, .charge_q, .charge_time_q, .cell_prot_en_q);

// ==== dv/bms_adc_model.sv ====
// Behavioural voltage converter and current decimator.
// Assumes one start per slot, spaced well beyond the conversion delay.
module bms_adc_model #(
    parameter int DLY = 5
) (
    input wire logic clk_sys,
    input wire logic adc_start_q,
    input wire logic [4:0] adc_chan_q,
    input wire logic ovr_req,
    input wire logic [23:0] cur_val,
    output logic adc_done,
    output logic [23:0] adc_data,
    output logic adc_ovr,
    output logic cc_valid,
    output logic [23:0] cc_data
);
    int cnt_q = 0;
    logic [2:0] cc_q = 3'h0;
    initial begin
        adc_done = 1'b0;
        adc_data = 24'h0;
        adc_ovr = 1'b0;
        cc_valid = 1'b0;
        cc_data = 24'h0;
    end
    // Buses toggle when not qualified so a stale value is never mistaken.
    always @(posedge clk_sys) begin
        adc_done <= 1'b0;
        adc_ovr <= 1'b0;
        adc_data <= ~adc_data;
        if (adc_start_q)
            cnt_q <= DLY;
        else if (cnt_q > 0)
            cnt_q <= cnt_q - 1;
        if (cnt_q == 1) begin
            adc_done <= 1'b1;
            adc_ovr <= ovr_req;
            adc_data <= {3'h0, adc_chan_q + 5'h1, 16'h0};
        end
        cc_q <= cc_q + 3'h1;
        cc_valid <= (cc_q == 3'h7);
        cc_data <= (cc_q == 3'h7) ? cur_val : ~cc_data;
    end
endmodule

// ==== dv/tb_battery_measurement_sequencer.sv ====
// Self-checking bench for the measurement sequencer, shortened counts.
// Assumes the converter model and the bound checker alongside.
`include "bms_params.svh"
module tb_battery_measurement_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [23:0] CUR = 24'hfedcb7;
    typedef struct {
        logic [4:0] sel;
        logic [15:0] mv;
        logic [31:0] raw;
        logic [15:0] cur;
    } bms_row_t;
    logic clk_sys, rst_n, run_en, fast_slot, host_reset_cmd, ovr_req;
    logic [7:0] idle_slots, avg_count, suv_delay_s;
    logic [15:0] cell_used, suv_threshold_mv;
    logic [8:0] aux_en;
    logic [4:0] rd_sel, adc_chan_q, loop_len_q;
    logic [23:0] adc_data, cc_data, cur_val;
    logic adc_start_q, adc_bandgap_q, adc_done, adc_ovr, cc_valid;
    logic [15:0] rd_mv_q, rd_cur_q, slow_cur_q, fast_cur_q, cell_prot_en_q;
    logic [31:0] rd_raw_q, fast_raw_q, avg_cur_q, charge_time_q, ts1_raw_q;
    logic [63:0] charge_q;
    logic slow_valid_q, suv_alert_q, suv_fault_q, loop_done_q;
    int n_errors = 0;
    int checked = 0;
    int cyc;
    bms_row_t rows [23];

    bms_meas_seq #(.SLOT_CYC(40), .SLOT_FAST_CYC(20), .CC1_CYC(800),
        .SEC_CYC(1600)) dut (.clk_sys, .rst_n, .run_en, .fast_slot,
        .idle_slots, .cell_used, .aux_en, .avg_count, .host_reset_cmd,
        .suv_threshold_mv, .suv_delay_s, .adc_start_q, .adc_chan_q,
        .adc_bandgap_q, .adc_done, .adc_data, .adc_ovr, .cc_valid, .cc_data,
        .rd_sel, .rd_mv_q, .rd_raw_q, .rd_cur_q, .slow_cur_q, .slow_valid_q,
        .fast_cur_q, .fast_raw_q, .avg_cur_q, .charge_q, .charge_time_q,
        .ts1_raw_q, .cell_prot_en_q, .suv_alert_q, .suv_fault_q,
        .loop_len_q, .loop_done_q);
    bms_adc_model u_adc (.clk_sys, .adc_start_q, .adc_chan_q, .ovr_req,
        .cur_val, .adc_done, .adc_data, .adc_ovr, .cc_valid, .cc_data);

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Returns the cycles from the call to the next loop start; gives up at 4000.
    task automatic wait_loop(output int c);
        c = 0;
        do begin
            tick(1);
            c++;
        end while (loop_done_q !== 1'b1 && c < 4000);
        if (c >= 4000) begin
            n_errors++;
            test_done();
        end
    endtask
    function automatic logic [23:0] code_of(input int c);
        return {3'h0, 5'(c + 1), 16'h0};
    endfunction
    function automatic logic [15:0] mv_of(input logic [23:0] code,
                                          input logic [15:0] gain);
        logic [31:0] p;
        p = {16'h0, code[23:8]} * {16'h0, gain};
        return p[31:16];
    endfunction

    initial begin
        rst_n = 1'b0;
        run_en = 1'b1;
        fast_slot = 1'b0;
        idle_slots = 8'h01;
        cell_used = 16'h7fff;
        aux_en = 9'h001;
        avg_count = 8'h04;
        host_reset_cmd = 1'b0;
        suv_threshold_mv = 16'h0100;
        suv_delay_s = 8'h00;
        rd_sel = 5'h0;
        ovr_req = 1'b0;
        cur_val = CUR;
        for (int c = 0; c < 23; c++) begin
            rows[c].sel = 5'(c);
            rows[c].raw = {8'h0, code_of(c)};
            rows[c].cur = (c < 16) ? CUR[23:8] : 16'h0;
            if (c < 22)
                rows[c].mv = mv_of(code_of(c), `BMS_CELL_GAIN);
            else
                rows[c].mv = mv_of(code_of(c), `BMS_AUX_GAIN);
        end
        tick(12);
        check(loop_len_q, 5'h12);
        check(charge_q, 64'h0);
        rst_n = 1'b1;
        // Three loops give every rotated source one conversion.
        wait_loop(cyc);
        wait_loop(cyc);
        wait_loop(cyc);
        check(cyc, 800);
        tick(2);
        for (int i = 0; i < 23; i++) begin
            rd_sel = rows[i].sel;
            tick(2);
            check(rd_mv_q, rows[i].mv);
            check(rd_raw_q, rows[i].raw);
            check(rd_cur_q, rows[i].cur);
        end
        check(ts1_raw_q, {8'h0, code_of(22)});
        check(cell_prot_en_q, 16'h7fff);
        check(loop_len_q, 5'h13);
        check(fast_raw_q, {8'hff, CUR});
        check(fast_cur_q, CUR[23:8]);
        check(avg_cur_q, {8'hff, CUR});
        check(suv_alert_q, 1'b1);
        check(suv_fault_q, 1'b0);
        // Host side: three first-cell reads, a whole loop apart, must agree.
        rd_sel = 5'h0;
        for (int i = 0; i < 3; i++) begin
            wait_loop(cyc);
            tick(2);
            check(rd_mv_q, rows[0].mv);
        end
        check(suv_alert_q, rows[0].mv < suv_threshold_mv);
        host_reset_cmd = 1'b1;
        tick(1);
        host_reset_cmd = 1'b0;
        check(charge_q, 64'h0);
        check(charge_time_q, 32'h0);
        cyc = 0;
        while (slow_valid_q !== 1'b1 && cyc < 1000) begin
            tick(1);
            cyc++;
        end
        check(cyc < 1000, 1'b1);
        if (cyc >= 1000)
            test_done();
        tick(2);
        check(slow_cur_q, CUR[23:8]);
        check(charge_q, {{48{CUR[23]}}, CUR[23:8]} << 30);
        run_en = 1'b0;
        fast_slot = 1'b1;
        idle_slots = 8'h00;
        aux_en = 9'h01f;
        ovr_req = 1'b1;
        tick(2);
        run_en = 1'b1;
        wait_loop(cyc);
        wait_loop(cyc);
        check(cyc, 420);
        check(loop_len_q, 5'h15);
        check(fast_raw_q, {8'hff, CUR & `BMS_FAST_MASK});
        rd_sel = 5'h3;
        tick(2);
        check(rd_raw_q, 32'h007fffff);
        check(rd_mv_q, mv_of(24'h7fffff, `BMS_CELL_GAIN));
        rst_n = 1'b0;
        tick(2);
        check(loop_len_q, 5'h12);
        check(charge_q, 64'h0);
        check(adc_start_q, 1'b0);
        rst_n = 1'b1;
        tick(1);
        check(adc_start_q, 1'b1);
        check(adc_chan_q, 5'h0);
        tick(1);
        check(adc_start_q, 1'b0);
        test_done();
    end
endmodule
